// >>> design/byte_fifo.v
`timescale 1ns/100ps
`default_nettype none

module byte_fifo #(
    parameter WIDTH = 8,
    parameter DEPTH = 8,
    parameter AW    = 3
) (
    // Clock and reset.
    input  wire             i_clk,
    input  wire             i_rstn,
    input  wire             i_flush,
    // Fill side.
    input  wire             i_valid,
    output wire             o_ready,
    input  wire [WIDTH-1:0] i_data,
    // Drain side.
    output wire             o_valid,
    input  wire             i_ready,
    output wire [WIDTH-1:0] o_data
);

    reg [WIDTH-1:0] mem [0:DEPTH-1];
    reg [AW-1:0]    wr_ptr;
    reg [AW-1:0]    rd_ptr;
    reg [AW:0]      count;
    wire            push;
    wire            pop;
    integer         k;

    assign o_ready = (count != DEPTH[AW:0]);
    assign o_valid = (count != {(AW+1){1'b0}});
    assign o_data  = mem[rd_ptr];
    assign push    = i_valid & o_ready;
    assign pop     = o_valid & i_ready;

    always @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            wr_ptr <= {AW{1'b0}};
            rd_ptr <= {AW{1'b0}};
            count  <= {(AW+1){1'b0}};
            for (k = 0; k < DEPTH; k = k + 1) begin
                mem[k] <= {WIDTH{1'b0}};
            end
        end else if (i_flush) begin
            wr_ptr <= {AW{1'b0}};
            rd_ptr <= {AW{1'b0}};
            count  <= {(AW+1){1'b0}};
        end else begin
            if (push) begin
                mem[wr_ptr] <= i_data;
                wr_ptr      <= wr_ptr + 1'b1;
            end
            if (pop) begin
                rd_ptr <= rd_ptr + 1'b1;
            end
            if (push & ~pop) begin
                count <= count + 1'b1;
            end else if (pop & ~push) begin
                count <= count - 1'b1;
            end
        end
    end

endmodule

`default_nettype wire

// >>> design/two_wire_regs.vh
`ifndef TWO_WIRE_REGS_VH
`define TWO_WIRE_REGS_VH

// Register byte offsets.
`define OFS_OWN_ADDR   8'h00
`define OFS_CONTROL    8'h04
`define OFS_STATUS     8'h08
`define OFS_DATA       8'h0C

// Reset values.
`define RST_OWN_ADDR   8'h00
`define RST_CONTROL    8'h00
`define RST_PRESCALE   2'h0

// Control register bit positions.
`define BIT_FLAG       7
`define BIT_ACK_EN     6
`define BIT_START_REQ  5
`define BIT_STOP_REQ   4
`define BIT_WCOL       3
`define BIT_IFACE_EN   2
`define BIT_IRQ_EN     0

// Own address register fields.
`define BIT_GC_EN      0
`define GC_ADDR        7'h00

// Status codes, prescaler bits taken as zero.
`define ST_OWN_W       8'h60
`define ST_ARB_OWN_W   8'h68
`define ST_GC          8'h70
`define ST_ARB_GC      8'h78
`define ST_DATA_ACK    8'h80
`define ST_DATA_NACK   8'h88
`define ST_GC_ACK      8'h90
`define ST_GC_NACK     8'h98
`define ST_IDLE        8'hF8

// Bits in one byte on the wire.
`define BYTE_BITS      4'h8

`endif

// >>> design/two_wire_slave_receiver.v
`timescale 1ns/100ps
`default_nettype none
`include "two_wire_regs.vh"

module two_wire_slave_receiver #(
    parameter FIFO_DEPTH = 8,
    parameter FIFO_AW    = 3
) (
    // Clock and reset.
    input  wire        I_REF_CLK,
    input  wire        I_RSTN,
    // APB slave.
    input  wire        I_PSEL,
    input  wire        I_PENABLE,
    input  wire        I_PWRITE,
    input  wire [7:0]  I_PADDR,
    input  wire [31:0] I_PWDATA,
    output reg  [31:0] O_PRDATA,
    output wire        O_PREADY,
    output wire        O_PSLVERR,
    // Two-wire bus pins.
    input  wire        I_SCL,
    output wire        O_SCL,
    output wire        O_SCL_OE,
    input  wire        I_SDA,
    output wire        O_SDA,
    output wire        O_SDA_OE,
    // Power and master-side status.
    input  wire        I_DEEP_SLEEP,
    input  wire        I_ARB_LOST,
    output reg         O_WAKE
);

    localparam S_IDLE = 6'b000001;
    localparam S_ADDR = 6'b000010;
    localparam S_ACK  = 6'b000100;
    localparam S_HOLD = 6'b001000;
    localparam S_DATA = 6'b010000;
    localparam S_SKIP = 6'b100000;

    // Status chosen when a byte has been acknowledged or refused.
    function [7:0] status_code;
        input addr_phase;
        input gc;
        input arb;
        input nack;
        begin
            if (addr_phase) begin
                if (gc) begin
                    status_code = arb ? `ST_ARB_GC : `ST_GC;
                end else begin
                    status_code = arb ? `ST_ARB_OWN_W : `ST_OWN_W;
                end
            end else if (gc) begin
                status_code = nack ? `ST_GC_NACK : `ST_GC_ACK;
            end else begin
                status_code = nack ? `ST_DATA_NACK : `ST_DATA_ACK;
            end
        end
    endfunction

    reg  [7:0]  own_slave_address;
    reg         ack_enable;
    reg         start_request;
    reg         stop_request;
    reg         iface_enable;
    reg         irq_enable;
    reg         irq_flag;
    reg  [7:0]  status;
    reg  [1:0]  prescale;
    reg  [5:0]  state;
    reg  [3:0]  bit_cnt;
    reg  [7:0]  shifter;
    reg         ack_drive;
    reg         addr_phase;
    reg         gc_mode;
    reg         nack_sent;
    reg         push_pending;
    reg         scl_m;
    reg         scl_s;
    reg         scl_d;
    reg         sda_m;
    reg         sda_s;
    reg         sda_d;
    wire        scl_rise;
    wire        scl_fall;
    wire        bus_start;
    wire        bus_stop;
    wire        own_match;
    wire        gc_match;
    wire        addr_ok;
    wire        wr_en;
    wire        rd_en;
    wire        setup;
    reg         hit;
    wire        flag_set;
    wire        flag_clr;
    wire        fifo_ready;
    wire        fifo_valid;
    wire        fifo_pop;
    wire [7:0]  fifo_data;
    wire [7:0]  control;
    wire        flush;

    // Bus pins are sampled twice before any use.
    always @(posedge I_REF_CLK or negedge I_RSTN) begin
        if (!I_RSTN) begin
            scl_m <= 1'b1;
            scl_s <= 1'b1;
            scl_d <= 1'b1;
            sda_m <= 1'b1;
            sda_s <= 1'b1;
            sda_d <= 1'b1;
        end else begin
            scl_m <= I_SCL;
            scl_s <= scl_m;
            scl_d <= scl_s;
            sda_m <= I_SDA;
            sda_s <= sda_m;
            sda_d <= sda_s;
        end
    end

    assign scl_rise  = scl_s & ~scl_d;
    assign scl_fall  = ~scl_s & scl_d;
    assign bus_start = scl_s & scl_d & sda_d & ~sda_s;
    assign bus_stop  = scl_s & scl_d & ~sda_d & sda_s;

    assign own_match = (shifter[7:1] == own_slave_address[7:1]);
    assign gc_match  = (shifter[7:1] == `GC_ADDR)
                     & own_slave_address[`BIT_GC_EN];
    assign addr_ok   = (own_match | gc_match) & ack_enable & iface_enable;

    assign flag_set  = state[2] & scl_fall;
    assign flush     = flag_set & addr_phase & I_DEEP_SLEEP;

    // Receive state machine.
    always @(posedge I_REF_CLK or negedge I_RSTN) begin
        if (!I_RSTN) begin
            state        <= S_IDLE;
            bit_cnt      <= 4'h0;
            shifter      <= 8'h00;
            ack_drive    <= 1'b0;
            addr_phase   <= 1'b0;
            gc_mode      <= 1'b0;
            nack_sent    <= 1'b0;
            push_pending <= 1'b0;
            status       <= `ST_IDLE;
            O_WAKE       <= 1'b0;
        end else begin
            O_WAKE <= 1'b0;
            if (bus_stop | ~iface_enable) begin
                state     <= S_IDLE;
                ack_drive <= 1'b0;
            end else if (bus_start & ~state[3]) begin
                state     <= S_ADDR;
                bit_cnt   <= 4'h0;
                ack_drive <= 1'b0;
            end else begin
                case (state)
                    S_ADDR, S_DATA: begin
                        if (scl_rise & (bit_cnt != `BYTE_BITS)) begin
                            shifter <= {shifter[6:0], sda_s};
                            bit_cnt <= bit_cnt + 4'h1;
                        end else if (scl_fall & (bit_cnt == `BYTE_BITS)) begin
                            if (state[1]) begin
                                if (addr_ok & ~shifter[0]) begin
                                    ack_drive  <= 1'b1;
                                    addr_phase <= 1'b1;
                                    gc_mode    <= gc_match & ~own_match;
                                    nack_sent  <= 1'b0;
                                    state      <= S_ACK;
                                end else begin
                                    // Transmit mode and foreign addresses are
                                    // left to other logic; bus is only watched.
                                    state <= S_SKIP;
                                end
                            end else begin
                                ack_drive  <= ack_enable;
                                nack_sent  <= ~ack_enable;
                                addr_phase <= 1'b0;
                                state      <= S_ACK;
                            end
                        end
                    end
                    S_ACK: begin
                        if (scl_fall) begin
                            ack_drive    <= 1'b0;
                            bit_cnt      <= 4'h0;
                            push_pending <= ~addr_phase;
                            status       <= status_code(addr_phase, gc_mode,
                                                        I_ARB_LOST, nack_sent);
                            state        <= S_HOLD;
                            if (addr_phase & I_DEEP_SLEEP) begin
                                O_WAKE <= 1'b1;
                            end
                        end
                    end
                    S_HOLD: begin
                        if (push_pending & fifo_ready) begin
                            push_pending <= 1'b0;
                        end
                        // Release only once software cleared the flag.
                        if (~irq_flag & ~push_pending & ~flag_set) begin
                            status <= `ST_IDLE;
                            if (nack_sent) begin
                                state <= S_SKIP;
                            end else begin
                                state <= S_DATA;
                            end
                        end
                    end
                    S_SKIP: begin
                        ack_drive <= 1'b0;
                    end
                    default: begin
                        state <= S_IDLE;
                    end
                endcase
            end
        end
    end

    // Clock is stretched while holding; pins only ever pull low.
    assign O_SCL    = 1'b0;
    assign O_SCL_OE = state[3];
    assign O_SDA    = 1'b0;
    assign O_SDA_OE = ack_drive;

    // APB decode.
    assign setup     = I_PSEL & ~I_PENABLE;
    assign wr_en     = I_PSEL & I_PENABLE & I_PWRITE;
    assign rd_en     = I_PSEL & I_PENABLE & ~I_PWRITE;
    // Unmapped offsets answer with an error and change nothing.
    always @* begin
        if (I_PADDR == `OFS_OWN_ADDR) begin
            hit = 1'b1;
        end else if (I_PADDR == `OFS_CONTROL) begin
            hit = 1'b1;
        end else if (I_PADDR == `OFS_STATUS) begin
            hit = 1'b1;
        end else if (I_PADDR == `OFS_DATA) begin
            hit = 1'b1;
        end else begin
            hit = 1'b0;
        end
    end
    assign O_PREADY  = 1'b1;
    assign O_PSLVERR = I_PSEL & I_PENABLE & ~hit;
    assign flag_clr  = wr_en & (I_PADDR == `OFS_CONTROL) & I_PWDATA[`BIT_FLAG];
    assign fifo_pop  = rd_en & (I_PADDR == `OFS_DATA);
    assign control   = {irq_flag, ack_enable, start_request, stop_request,
                        1'b0, iface_enable, 1'b0, irq_enable};

    // Software-visible registers.
    always @(posedge I_REF_CLK or negedge I_RSTN) begin
        if (!I_RSTN) begin
            own_slave_address <= `RST_OWN_ADDR;
            ack_enable        <= 1'b0;
            start_request     <= 1'b0;
            stop_request      <= 1'b0;
            iface_enable      <= 1'b0;
            irq_enable        <= 1'b0;
            irq_flag          <= 1'b0;
            prescale          <= `RST_PRESCALE;
        end else begin
            if (flag_set) begin
                irq_flag <= 1'b1;
            end else if (flag_clr) begin
                irq_flag <= 1'b0;
            end
            if (wr_en) begin
                if (I_PADDR == `OFS_OWN_ADDR) begin
                    own_slave_address <= I_PWDATA[7:0];
                end else if (I_PADDR == `OFS_CONTROL) begin
                    ack_enable    <= I_PWDATA[`BIT_ACK_EN];
                    start_request <= I_PWDATA[`BIT_START_REQ];
                    stop_request  <= I_PWDATA[`BIT_STOP_REQ];
                    iface_enable  <= I_PWDATA[`BIT_IFACE_EN];
                    irq_enable    <= I_PWDATA[`BIT_IRQ_EN];
                end else if (I_PADDR == `OFS_STATUS) begin
                    prescale <= I_PWDATA[1:0];
                end
            end
        end
    end

    // Read data is captured in the setup cycle.
    always @(posedge I_REF_CLK or negedge I_RSTN) begin
        if (!I_RSTN) begin
            O_PRDATA <= 32'h0000_0000;
        end else if (setup & ~I_PWRITE) begin
            if (I_PADDR == `OFS_OWN_ADDR) begin
                O_PRDATA <= {24'h00_0000, own_slave_address};
            end else if (I_PADDR == `OFS_CONTROL) begin
                O_PRDATA <= {24'h00_0000, control};
            end else if (I_PADDR == `OFS_STATUS) begin
                O_PRDATA <= {24'h00_0000, status[7:3], 1'b0, prescale};
            end else if (I_PADDR == `OFS_DATA) begin
                O_PRDATA <= {24'h00_0000, fifo_valid ? fifo_data : 8'h00};
            end else begin
                O_PRDATA <= 32'h0000_0000;
            end
        end
    end

    // Received bytes wait here; a full buffer keeps the clock held low.
    // A deep-sleep wake empties it, so stale bytes are never shown.
    byte_fifo #(
        .WIDTH (8),
        .DEPTH (FIFO_DEPTH),
        .AW    (FIFO_AW)
    ) u_rx_fifo (
        .i_clk   (I_REF_CLK),
        .i_rstn  (I_RSTN),
        .i_flush (flush),
        .i_valid (push_pending & state[3]),
        .o_ready (fifo_ready),
        .i_data  (shifter),
        .o_valid (fifo_valid),
        .i_ready (fifo_pop),
        .o_data  (fifo_data)
    );

endmodule

`default_nettype wire

// >>> verification/testbench.sv
`timescale 1ns/100ps
`default_nettype none
`include "two_wire_regs.vh"
module testbench;
    logic        clk;
    logic        rstn = 1'b0;
    logic        psel = 1'b0;
    logic        pen = 1'b0;
    logic        pwr = 1'b0;
    logic [7:0]  paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic        sleep = 1'b0;
    logic        arb = 1'b0;
    logic [7:0]  ctl = 8'h00;
    wire  [31:0] prdata;
    wire         pready, pslverr, scl_out, scl_oe, sda_out, sda_oe, wake, m_scl, m_sda, stuck;
    wire         scl = ~((scl_oe & ~scl_out) | m_scl);
    wire         sda = ~((sda_oe & ~sda_out) | m_sda);
    int          err_total = 0;
    int          tests_run = 0;
    int          wakes = 0;
    two_wire_slave_receiver #(.FIFO_DEPTH(8), .FIFO_AW(3)) DUT (
        .I_REF_CLK(clk), .I_RSTN(rstn), .I_PSEL(psel), .I_PENABLE(pen), .I_PWRITE(pwr),
        .I_PADDR(paddr), .I_PWDATA(pwdata), .O_PRDATA(prdata), .O_PREADY(pready),
        .O_PSLVERR(pslverr), .I_SCL(scl), .O_SCL(scl_out), .O_SCL_OE(scl_oe), .I_SDA(sda),
        .O_SDA(sda_out), .O_SDA_OE(sda_oe), .I_DEEP_SLEEP(sleep), .I_ARB_LOST(arb),
        .O_WAKE(wake));
    tw_master_model master (.i_clk(clk), .i_scl(scl), .i_sda(sda), .o_scl_low(m_scl),
        .o_sda_low(m_sda), .o_stuck(stuck));
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    always @(posedge clk) if (wake === 1'b1) wakes <= wakes + 1;
    task automatic conclude;
        $display("comparisons %0d mismatches %0d", tests_run, err_total);
        if (err_total == 0 && tests_run > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask
    task automatic check(input logic [31:0] s, input logic [31:0] x);
        tests_run++;
        if (s !== x) begin
            err_total++;
            $display("mismatch at %0t: seen %h expected %h", $time, s, x);
        end
    endtask
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                       output logic [31:0] r, output logic e);
        int n;
        begin
            psel <= 1'b1;
            pwr <= w;
            paddr <= a;
            pwdata <= d;
            @(posedge clk);
            pen <= 1'b1;
            n = 0;
            do begin
                @(posedge clk);
                n++;
            end while (pready !== 1'b1 && n < 50);
            if (n >= 50) begin
                err_total++;
                conclude;
            end
            r = prdata;
            e = pslverr;
            psel <= 1'b0;
            pen <= 1'b0;
            @(posedge clk);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] r;
        logic        e;
        apb(1'b1, a, d, r, e);
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] x);
        logic [31:0] r;
        logic        e;
        apb(1'b0, a, 32'h0, r, e);
        check(r, x);
    endtask
    task automatic clr;
        wr(`OFS_CONTROL, {24'h0, ctl | 8'h80});
    endtask
    // Sends one byte, then checks the answer bit and the status that follows.
    task automatic dat(input logic [7:0] b, input logic xa, input logic [7:0] xs);
        logic a;
        master.send(b, a);
        check(32'(a), 32'(xa));
        rd(`OFS_STATUS, {24'h0, xs});
    endtask
    task automatic addr(input logic [7:0] b, input logic xa, input logic [7:0] xs);
        master.start;
        dat(b, xa, xs);
    endtask
    initial begin
        repeat (100000) @(posedge clk);
        err_total++;
        conclude;
    end
    always @(posedge stuck) begin
        err_total++;
        conclude;
    end
    initial begin
        logic [31:0] r;
        logic        e;
        int          n;
        logic [7:0]  ga [4] = '{8'h00, 8'h00, 8'h54, 8'h54};
        logic [7:0]  gs [4] = '{`ST_GC, `ST_ARB_GC, `ST_OWN_W, `ST_ARB_OWN_W};
        logic [7:0]  na [3] = '{8'h00, 8'h55, 8'h56};
        repeat (12) @(posedge clk);
        rstn <= 1'b1;
        @(posedge clk);
        rd(`OFS_OWN_ADDR, 32'h0);
        rd(`OFS_CONTROL, 32'h0);
        rd(`OFS_STATUS, 32'h0000_00F8);
        rd(`OFS_DATA, 32'h0);
        apb(1'b1, 8'h10, 32'h0000_00FF, r, e);
        check(32'(e), 32'h1);
        wr(`OFS_STATUS, 32'h0000_0003);
        rd(`OFS_STATUS, 32'h0000_00FB);
        wr(`OFS_STATUS, 32'h0);
        wr(`OFS_OWN_ADDR, 32'h0000_0055);
        ctl = 8'h44;
        wr(`OFS_CONTROL, {24'h0, ctl});
        rd(`OFS_OWN_ADDR, 32'h0000_0055);
        for (int k = 0; k < 4; k++) begin
            arb <= k[0];
            addr(ga[k], 1'b1, gs[k]);
            clr;
            master.stop;
        end
        arb <= 1'b0;
        addr(8'h00, 1'b1, `ST_GC);
        clr;
        dat(8'h33, 1'b1, `ST_GC_ACK);
        clr;
        master.stop;
        rd(`OFS_DATA, 32'h0000_0033);
        wr(`OFS_OWN_ADDR, 32'h0000_0054);
        for (int k = 0; k < 3; k++) begin
            addr(na[k], 1'b0, `ST_IDLE);
            master.stop;
        end
        ctl = 8'h04;
        wr(`OFS_CONTROL, {24'h0, ctl});
        addr(8'h54, 1'b0, `ST_IDLE);
        master.stop;
        ctl = 8'h44;
        wr(`OFS_CONTROL, {24'h0, ctl});
        addr(8'h54, 1'b1, `ST_OWN_W);
        rd(`OFS_CONTROL, 32'h0000_00C4);
        check(32'(scl_oe), 32'h1);
        clr;
        rd(`OFS_CONTROL, 32'h0000_0044);
        dat(8'hA5, 1'b1, `ST_DATA_ACK);
        rd(`OFS_DATA, 32'h0000_00A5);
        ctl = 8'h04;
        clr;
        dat(8'h3C, 1'b0, `ST_DATA_NACK);
        ctl = 8'h44;
        clr;
        dat(8'h5A, 1'b0, `ST_IDLE);
        master.stop;
        sleep <= 1'b1;
        addr(8'h54, 1'b1, `ST_OWN_W);
        check(32'(wakes), 32'h1);
        check(32'(scl_oe), 32'h1);
        rd(`OFS_DATA, 32'h0);
        clr;
        sleep <= 1'b0;
        master.stop;
        addr(8'h54, 1'b1, `ST_OWN_W);
        clr;
        for (int i = 1; i < 10; i++) begin
            dat(8'(i), 1'b1, `ST_DATA_ACK);
            clr;
        end
        repeat (10) @(posedge clk);
        check(32'(scl_oe), 32'h1);
        rd(`OFS_DATA, 32'h1);
        n = 0;
        while (scl_oe !== 1'b0 && n < 20) begin
            @(posedge clk);
            n++;
        end
        check(32'(n < 20), 32'h1);
        for (int i = 2; i < 10; i++) rd(`OFS_DATA, 32'(i));
        rd(`OFS_DATA, 32'h0);
        master.stop;
        conclude;
    end
endmodule
`default_nettype wire

// >>> verification/tw_master_model.sv
`timescale 1ns/100ps
`default_nettype none
module tw_master_model (
    // Clock and bus levels.
    input  wire logic i_clk,
    input  wire logic i_scl,
    input  wire logic i_sda,
    // Open-drain pulls and hang report.
    output var logic  o_scl_low = 1'b0,
    output var logic  o_sda_low = 1'b0,
    output var logic  o_stuck = 1'b0
);
    task automatic pause(input int n);
        repeat (n) @(posedge i_clk);
    endtask
    // Releases the clock, waits out any stretch, then keeps it high.
    task automatic rise;
        int n;
        begin
            o_scl_low <= 1'b0;
            n = 0;
            while (i_scl !== 1'b1 && n < 3000) begin
                @(posedge i_clk);
                n++;
            end
            if (n >= 3000) o_stuck <= 1'b1;
            pause(7);
        end
    endtask
    task automatic start;
        o_sda_low <= 1'b1;
        pause(8);
        o_scl_low <= 1'b1;
    endtask
    // Data changes mid-low so no false start or stop is seen.
    task automatic send(input logic [7:0] b, output logic ack);
        for (int i = 7; i >= 0; i--) begin
            pause(4);
            o_sda_low <= ~b[i];
            pause(4);
            rise;
            o_scl_low <= 1'b1;
        end
        pause(4);
        o_sda_low <= 1'b0;
        pause(4);
        rise;
        ack = (i_sda === 1'b0);
        o_scl_low <= 1'b1;
        pause(8);
    endtask
    task automatic stop;
        pause(4);
        o_sda_low <= 1'b1;
        pause(4);
        rise;
        o_sda_low <= 1'b0;
        pause(8);
    endtask
endmodule
`default_nettype wire

// >>> verification/tw_slave_chk.sv
`timescale 1ns/100ps
`default_nettype none
`include "two_wire_regs.vh"
module tw_slave_chk (
    // Clock, reset and register bus.
    input wire logic        I_REF_CLK,
    input wire logic        I_RSTN,
    input wire logic        I_PSEL,
    input wire logic        I_PENABLE,
    input wire logic        I_PWRITE,
    input wire logic [7:0]  I_PADDR,
    input wire logic [31:0] I_PWDATA,
    // Bus pins and sleep.
    input wire logic        O_SCL_OE,
    input wire logic        O_SDA_OE,
    input wire logic        I_DEEP_SLEEP,
    input wire logic        O_WAKE
);
    logic ack_en;
    logic if_en;
    logic clr_seen;
    wire  wr_ctl = I_PSEL && I_PENABLE && I_PWRITE && I_PADDR == `OFS_CONTROL;
    default clocking @(posedge I_REF_CLK); endclocking
    default disable iff (!I_RSTN);
    // Shadow of the enables and of a flag clear not yet answered.
    always_ff @(posedge I_REF_CLK or negedge I_RSTN) begin
        if (!I_RSTN) begin
            ack_en   <= 1'b0;
            if_en    <= 1'b0;
            clr_seen <= 1'b0;
        end else begin
            if (wr_ctl) begin
                ack_en <= I_PWDATA[`BIT_ACK_EN];
                if_en  <= I_PWDATA[`BIT_IFACE_EN];
            end
            clr_seen <= (wr_ctl && I_PWDATA[`BIT_FLAG]) || (clr_seen && O_SCL_OE);
        end
    end
    chk_ack_needs_en: assert property ($rose(O_SDA_OE) |-> ack_en && if_en)
        else $error("acknowledge driven while disabled");
    chk_ack_then_hold: assert property ($rose(O_SDA_OE) |-> O_SDA_OE[*8] ##[1:30] ($fell(O_SDA_OE) && O_SCL_OE))
        else $error("acknowledge did not end in a held clock");
    chk_release_clear: assert property ($fell(O_SCL_OE) |-> $past(clr_seen))
        else $error("clock released without a flag clear");
    chk_hold_till_clr: assert property (O_SCL_OE && !clr_seen |=> O_SCL_OE)
        else $error("clock hold dropped early");
    chk_quiet_hold: assert property (O_SCL_OE |-> !O_SDA_OE)
        else $error("data line pulled while clock held");
    chk_wake_in_sleep: assert property (O_WAKE |-> $past(I_DEEP_SLEEP) && ack_en)
        else $error("wake outside deep sleep");
    chk_wake_pulse: assert property (O_WAKE |=> !O_WAKE)
        else $error("wake longer than one cycle");
    chk_wake_holds: assert property (O_WAKE |-> ##[0:40] O_SCL_OE)
        else $error("wake without a clock hold");
endmodule
bind two_wire_slave_receiver tw_slave_chk u_chk (
    .I_REF_CLK(I_REF_CLK), .I_RSTN(I_RSTN), .I_PSEL(I_PSEL), .I_PENABLE(I_PENABLE),
    .I_PWRITE(I_PWRITE), .I_PADDR(I_PADDR), .I_PWDATA(I_PWDATA), .O_SCL_OE(O_SCL_OE),
    .O_SDA_OE(O_SDA_OE), .I_DEEP_SLEEP(I_DEEP_SLEEP), .O_WAKE(O_WAKE));
`default_nettype wire
